// ### plm_pkg.sv
// Purpose: Shared constants and types of the output macrocell array.
// Assumes: Eight macrocells with eight product terms each.
// Notes:   Registers are reached over AXI4-Lite, one 32-bit word each.

package plm_pkg;

    // ==========================================================
    // Array shape
    localparam int NCELL  = 8;
    localparam int NPT    = 8;
    localparam int CTR_LO = 3;
    localparam int CTR_HI = 4;
    localparam int OUT_LO = 0;
    localparam int OUT_HI = 7;

    // ==========================================================
    // Global modes and per-cell settings
    typedef enum logic [2:0] {
        PLM_MODE_REG  = 3'h1,
        PLM_MODE_CPLX = 3'h2,
        PLM_MODE_SMPL = 3'h4
    } plm_mode_t;

    typedef enum logic [1:0] {
        PLM_CFG_IN   = 2'h0,
        PLM_CFG_COMB = 2'h1,
        PLM_CFG_REG  = 2'h2,
        PLM_CFG_RSV  = 2'h3
    } plm_cfg_t;

    typedef struct packed {
        logic reg_en;
        logic pt_oe;
        logic drive_on;
        logic drive_off;
    } plm_cell_ctl_t;

    // ==========================================================
    // Register map
    localparam logic [3:0]  CTRL_ADDR     = 4'h0;
    localparam logic [3:0]  CELL_ADDR     = 4'h4;
    localparam logic [3:0]  STAT_ADDR     = 4'h8;
    localparam int          RUN_BIT       = 8;
    localparam int          MODE_W        = 3;
    localparam int          CFG_W         = 2 * NCELL;
    localparam plm_mode_t   MODE_RST      = PLM_MODE_REG;
    localparam logic [15:0] CELL_RST      = 16'h5555;
    localparam int          STAT_OE_LSB   = 8;
    localparam int          STAT_Q_LSB    = 16;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ### plm_macrocell.sv
// Purpose: One output macrocell: sum term, flip-flop and output enable.
// Assumes: Control bits are held steady by the array while running.
// Notes:   The flip-flop captures on a one-cycle capture pulse.

`timescale 1ns/1ps

module plm_macrocell #(
    parameter int NPT = 8
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Array side
    input  wire logic [NPT-1:0]        pt,
    input  wire plm_pkg::plm_cell_ctl_t ctl,
    input  wire logic                  cap,
    input  wire logic                  oe_n_pin,
    // Pin side
    output logic                       pin_out,
    output logic                       pin_oe,
    output logic                       q
);

    // ==========================================================
    // Sum term
    wire sum_all = |pt;
    wire sum_low = |pt[NPT-1:1];
    wire sum     = ctl.pt_oe ? sum_low : sum_all;

    // ==========================================================
    // Register, cleared to low by reset
    // reset clears flop
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= 1'b0;
        else if (cap && ctl.reg_en)
            q <= sum_all;
    end

    // ==========================================================
    // Output and its enable
    assign pin_out = ctl.reg_en ? ~q : sum;
    assign pin_oe  = ctl.drive_off ? 1'b0 :
                     ctl.reg_en    ? ~oe_n_pin :
                     ctl.pt_oe     ? pt[0] : ctl.drive_on;

endmodule // plm_macrocell

// ### plm_macrocell_array.sv
// Purpose: Eight configurable output macrocells in three global modes.
// Assumes: Product terms come from an AND array outside; pins are synchronous.
// Notes:   Mode and cell settings change only while the run bit is low.

`timescale 1ns/1ps

module plm_macrocell_array #(
    parameter int ADDR_W = 4,
    parameter int NCELL  = plm_pkg::NCELL,
    parameter int NPT    = plm_pkg::NPT
) (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Shared clock and active-low enable pins
    input  wire logic                   clk_pin,
    input  wire logic                   oe_n_pin,
    // Product terms from the AND array
    input  wire logic [NCELL*NPT-1:0]   pterm,
    // Feedback into the AND array
    output logic [NCELL-1:0]            array_fb,
    output logic [1:0]                  array_aux,
    // Macrocell pins
    input  wire logic [NCELL-1:0]       io_in,
    output logic [NCELL-1:0]            io_out,
    output logic [NCELL-1:0]            io_oe
);

    // ==========================================================
    // Configuration state
    plm_pkg::plm_mode_t   mode;
    logic [2*NCELL-1:0]   cell_cfg;
    logic                 run;
    logic [NCELL-1:0]     reg_q;
    logic                 clk_pin_q;

    wire is_reg  = (mode == plm_pkg::PLM_MODE_REG);
    wire is_cplx = (mode == plm_pkg::PLM_MODE_CPLX);
    wire is_smpl = (mode == plm_pkg::PLM_MODE_SMPL);

    // ==========================================================
    // Write channel
    logic                 aw_held;
    logic                 w_held;
    logic [ADDR_W-1:0]    waddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;

    wire aw_ok    = s_axi_awvalid && s_axi_awready;
    wire w_ok     = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire b_done   = s_axi_bvalid && s_axi_bready;
    wire sel_ctrl = (waddr == ADDR_W'(plm_pkg::CTRL_ADDR));
    wire sel_cell = (waddr == ADDR_W'(plm_pkg::CELL_ADDR));
    wire sel_stat = (waddr == ADDR_W'(plm_pkg::STAT_ADDR));
    wire w_mapped = sel_ctrl || sel_cell || sel_stat;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    // Only a one-hot mode value is accepted.
    wire [2:0] wmode    = wdata[plm_pkg::MODE_W-1:0];
    wire       mode_ok  = (wmode == 3'h1) || (wmode == 3'h2) || (wmode == 3'h4);
    wire wr_mode = do_write && sel_ctrl && wstrb[0] && !run && mode_ok;
    wire wr_run  = do_write && sel_ctrl && wstrb[1];
    wire wr_cfg0 = do_write && sel_cell && wstrb[0] && !run;
    wire wr_cfg1 = do_write && sel_cell && wstrb[1] && !run;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            waddr   <= '0;
        end
        else if (aw_ok)
        begin
            aw_held <= 1'b1;
            waddr   <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            wdata  <= 32'h0;
            wstrb  <= 4'h0;
        end
        else if (w_ok)
        begin
            w_held <= 1'b1;
            wdata  <= s_axi_wdata;
            wstrb  <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= plm_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= w_mapped ? plm_pkg::RESP_OKAY : plm_pkg::RESP_SLVERR;
        end
        else if (b_done)
            s_axi_bvalid <= 1'b0;
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode     <= plm_pkg::MODE_RST;
            run      <= 1'b0;
            cell_cfg <= plm_pkg::CELL_RST;
        end
        else
        begin
            if (wr_mode)
                mode <= plm_pkg::plm_mode_t'(wmode);
            if (wr_run)
                run <= wdata[plm_pkg::RUN_BIT];
            if (wr_cfg0)
                cell_cfg[7:0] <= wdata[7:0];
            if (wr_cfg1)
                cell_cfg[15:8] <= wdata[15:8];
        end
    end

    // ==========================================================
    // Read channel
    wire ar_ok   = s_axi_arvalid && s_axi_arready;
    wire rs_ctrl = (s_axi_araddr == ADDR_W'(plm_pkg::CTRL_ADDR));
    wire rs_cell = (s_axi_araddr == ADDR_W'(plm_pkg::CELL_ADDR));
    wire rs_stat = (s_axi_araddr == ADDR_W'(plm_pkg::STAT_ADDR));

    wire [31:0] ctrl_word = {23'h0, run, 5'h0, mode};
    wire [31:0] cell_word = {16'h0, cell_cfg};
    wire [31:0] stat_word = {8'h0, reg_q, io_oe, io_out};
    wire [31:0] rd_mux    = rs_ctrl ? ctrl_word :
                            rs_cell ? cell_word :
                            rs_stat ? stat_word : 32'h0;
    wire        rd_ok     = rs_ctrl || rs_cell || rs_stat;

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= plm_pkg::RESP_OKAY;
        end
        else if (ar_ok)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? plm_pkg::RESP_OKAY : plm_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ==========================================================
    // Clock pin edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            clk_pin_q <= 1'b0;
        else
            clk_pin_q <= clk_pin;
    end

    wire cap = clk_pin && !clk_pin_q && run && is_reg;

    // ==========================================================
    // Macrocells
    plm_pkg::plm_cell_ctl_t ctl [NCELL];

    genvar i;
    generate
        for (i = 0; i < NCELL; i++)
        begin : g_cell
            wire [1:0] cfg    = cell_cfg[2*i +: 2];
            wire       c_in   = (cfg == plm_pkg::PLM_CFG_IN);
            wire       c_reg  = (cfg == plm_pkg::PLM_CFG_REG);
            wire       centre = (i == plm_pkg::CTR_LO) || (i == plm_pkg::CTR_HI);
            // simple mode has no term enable
            assign ctl[i].reg_en    = is_reg && c_reg;
            assign ctl[i].pt_oe     = (is_reg && !c_reg && !c_in) || is_cplx;
            assign ctl[i].drive_on  = is_smpl && (centre || !c_in);
            // other simple cells input or output
            assign ctl[i].drive_off = c_in && (is_reg || (is_smpl && !centre));

            plm_macrocell #(
                .NPT      (NPT)
            ) u_cell (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .pt       (pterm[NPT*i +: NPT]),
                .ctl      (ctl[i]),
                .cap      (cap),
                .oe_n_pin (oe_n_pin),
                .pin_out  (io_out[i]),
                .pin_oe   (io_oe[i]),
                .q        (reg_q[i])
            );

            wire fb_smpl;
            if (i == plm_pkg::OUT_LO || i == plm_pkg::OUT_HI)
            begin : g_edge
                assign fb_smpl = 1'b0;
            end
            else if (i <= plm_pkg::CTR_LO)
            begin : g_lo
                assign fb_smpl = io_in[i-1];
            end
            else
            begin : g_hi
                assign fb_smpl = io_in[i+1];
            end

            // outer paths carry former clock and enable pins
            wire fb_cplx;
            if (i == plm_pkg::OUT_LO)
            begin : g_oe
                assign fb_cplx = oe_n_pin;
            end
            else if (i == plm_pkg::OUT_HI)
            begin : g_ck
                assign fb_cplx = clk_pin;
            end
            else
            begin : g_io
                // inner pins back to the array
                assign fb_cplx = io_in[i];
            end

            assign array_fb[i] = is_reg  ? (c_reg ? reg_q[i] : io_in[i]) :
                                 is_cplx ? fb_cplx : fb_smpl;
        end
    endgenerate

    // clock and enable pins not array inputs here
    // simple mode uses them as plain inputs
    assign array_aux = is_smpl ? {clk_pin, oe_n_pin} : 2'h0;

    // ==========================================================
    // Checks
    wire [NCELL-1:0] regm;
    wire [NCELL-1:0] sum8;
    wire [NCELL-1:0] pt0;
    wire [NCELL-1:0] inm;
    generate
        for (i = 0; i < NCELL; i++)
        begin : g_chk
            assign regm[i] = ctl[i].reg_en;
            assign sum8[i] = |pterm[NPT*i +: NPT];
            assign pt0[i]  = pterm[NPT*i];
            assign inm[i]  = ctl[i].drive_off;
        end
    endgenerate

    reg_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ((io_oe & regm) == ({NCELL{~oe_n_pin}} & regm)))
        else $error("Registered cell enable does not follow enable pin.");

    reg_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap |=> ((reg_q & regm) == ($past(sum8) & regm)))
        else $error("Registered cell did not capture eight-term sum.");

    term_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        is_cplx |-> (io_oe == pt0))
        else $error("Complex cell enable does not follow first term.");

    comb_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
        is_reg |-> ((io_oe & ~(regm | inm)) == (pt0 & ~(regm | inm))))
        else $error("Registered-mode combinatorial enable does not follow first term.");

    input_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ((io_oe & inm) == '0))
        else $error("Input cell drives its pin.");

    aux_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !is_smpl |-> (array_aux == 2'h0))
        else $error("Clock or enable pin reached array outside simple mode.");

    outer_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
        is_cplx |-> (array_fb[7] == clk_pin && array_fb[0] == oe_n_pin))
        else $error("Complex outer feedback does not carry pins.");

    centre_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
        is_smpl |-> (io_oe[4:3] == 2'h3))
        else $error("Simple centre cell not driving.");

    reset_clear_a: assert property (@(posedge aclk)
        !aresetn |=> (reg_q == '0) && run == 1'b0)
        else $error("Registers not cleared by reset.");

    cfg_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run |=> $stable(mode) && $stable(cell_cfg))
        else $error("Settings changed while running.");

    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("Write response missing.");

    cap_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) cap);
    cplx_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) is_cplx && run);
    smpl_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) is_smpl && run);

endmodule // plm_macrocell_array

// ### plm_board_model.sv
// Purpose: Board-side model of the macrocell pins with weak pull-ups.
// Assumes: The bench chooses which pins the board drives and with what level.
// Notes:   A pin that nobody drives floats to the pull-up level.

`timescale 1ns/1ps

module plm_board_model (
    // Device pin side
    input  wire logic [7:0] io_out,
    input  wire logic [7:0] io_oe,
    // Board drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // Resolved pin levels
    output logic [7:0]      io_in
);
    // ==========================================================
    // Pin resolution
    // The device wins where it drives, then the board, else the pull-up.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            io_in[i] = io_oe[i] ? io_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule // plm_board_model

// ### plm_macrocell_array_tb.sv
// Purpose: Self-checking bench of the macrocell array in all three modes.
// Assumes: Registers at 0x0, 0x4 and 0x8; 0xc is unmapped.
// Notes:   Pins are driven on the rising clock edge.

`timescale 1ns/1ps

module plm_macrocell_array_tb;
    // ==========================================================
    // Signals
    logic aclk = 0, aresetn = 0, clk_pin = 0, oe_n_pin = 0;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] bresp, rresp, aux;
    logic [63:0] pterm = 0;
    logic [7:0] fb, io_in, io_out, io_oe, ext_en = 0, ext_val = 0;
    int fail_count = 0, checks_done = 0;
    logic [31:0] d;
    logic [1:0] r;

    plm_macrocell_array u_plm_macrocell_array (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .clk_pin(clk_pin),
        .oe_n_pin(oe_n_pin), .pterm(pterm), .array_fb(fb), .array_aux(aux),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe));

    plm_board_model u_plm_board_model (
        .io_out(io_out), .io_oe(io_oe), .ext_en(ext_en), .ext_val(ext_val), .io_in(io_in));

    initial
    begin
        forever #5 aclk = ~aclk;
    end

    // ==========================================================
    // Shared tasks
    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= v; wstrb <= 4'hf;
        awvalid <= 1; wvalid <= 1; bready <= 1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid && n < 50);
        rs = bresp;
        bready <= 0;
        if (n >= 50)
        begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid && n < 50);
        v = rdata;
        rs = rresp;
        rready <= 0;
        if (n >= 50)
        begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    // Lets pin changes settle, then samples off the edge.
    task automatic settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask

    // One rising edge on the shared clock pin, held long enough to be seen.
    task automatic pulse_clk_pin();
        @(posedge aclk);
        clk_pin <= 1;
        repeat (3) @(posedge aclk);
        clk_pin <= 0;
        settle();
    endtask

    // ==========================================================
    // Scenarios
    task automatic reset_and_map();
        axi_rd(4'h0, d, r);
        chk("ctrl reset", d, 32'h1);
        axi_rd(4'h4, d, r);
        chk("cell reset", d, 32'h5555);
        axi_rd(4'hc, d, r);
        chk("unmapped read resp", {30'h0, r}, 32'h2);
        axi_wr(4'hc, 32'hffff, r);
        chk("unmapped write resp", {30'h0, r}, 32'h2);
    endtask

    task automatic registered_mode();
        axi_wr(4'h4, 32'h6a86, r);
        axi_wr(4'h0, 32'h101, r);
        @(posedge aclk);
        pterm <= 64'h00000000_01000180;
        oe_n_pin <= 0;
        settle();
        chk("reg out after reset", {24'h0, io_out & 8'h79}, 32'h79);
        chk("reg mode enables", {24'h0, io_oe}, 32'h7b);
        chk("comb seven terms", {31'h0, io_out[1]}, 32'h0);
        chk("reg aux", {30'h0, aux}, 32'h0);
        pulse_clk_pin();
        chk("reg capture", {24'h0, io_out & 8'h79}, 32'h70);
        axi_rd(4'h8, d, r);
        chk("flop state", {24'h0, d[23:16]}, 32'h09);
        chk("reg feedback", {31'h0, fb[0]}, 32'h1);
        @(posedge aclk);
        oe_n_pin <= 1;
        settle();
        chk("enable pin off", {24'h0, io_oe}, 32'h02);
        axi_wr(4'h4, 32'h0, r);
        axi_wr(4'h0, 32'h102, r);
        axi_rd(4'h4, d, r);
        chk("cell locked", d, 32'h6a86);
        axi_rd(4'h0, d, r);
        chk("mode locked", d, 32'h101);
    endtask

    task automatic complex_mode();
        axi_wr(4'h0, 32'h0, r);
        axi_wr(4'h0, 32'h102, r);
        @(posedge aclk);
        pterm <= 64'h0000_0000_0000_0301;
        ext_en <= 8'h08;
        ext_val <= 8'h08;
        oe_n_pin <= 1;
        clk_pin <= 0;
        settle();
        chk("cplx enables", {24'h0, io_oe}, 32'h03);
        chk("cplx sums", {30'h0, io_out[1:0]}, 32'h2);
        chk("cplx feedback", {24'h0, fb & 8'h89}, 32'h09);
        chk("cplx inner pin", {31'h0, fb[3]}, 32'h1);
        @(posedge aclk);
        clk_pin <= 1;
        oe_n_pin <= 0;
        settle();
        chk("cplx outer paths", {24'h0, fb & 8'h81}, 32'h80);
        chk("cplx pins to array", {31'h0, fb[7]}, 32'h1);
    endtask

    task automatic simple_mode();
        axi_wr(4'h0, 32'h0, r);
        axi_wr(4'h4, 32'h0, r);
        axi_wr(4'h0, 32'h104, r);
        @(posedge aclk);
        pterm <= 64'h0101_0101_0101_0101;
        ext_en <= 8'he7;
        ext_val <= 8'ha5;
        clk_pin <= 1;
        oe_n_pin <= 0;
        settle();
        chk("simple enables", {24'h0, io_oe}, 32'h18);
        chk("simple eight terms", {30'h0, io_out[4:3]}, 32'h3);
        chk("simple feedback", {24'h0, fb}, 32'h5a);
        chk("simple aux", {30'h0, aux}, 32'h2);
        axi_wr(4'h0, 32'h0, r);
        axi_wr(4'h4, 32'h5555, r);
        axi_wr(4'h0, 32'h104, r);
        settle();
        chk("simple outputs on", {24'h0, io_oe}, 32'hff);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        reset_and_map();
        registered_mode();
        complex_mode();
        simple_mode();
        tally_and_finish();
    end
endmodule // plm_macrocell_array_tb
